// ===== rtl/pcpm_pkg.sv
// Constants, enums and carrier types of the power management register bank
// Assumes a 32-bit register port and a single 200 MHz clock domain
package pcpm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CAP = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_TABLE = 8'h0C;
  localparam logic [7:0] OFS_VARIANT = 8'h10;

  // Capability register field positions
  localparam int STATE_LSB = 0;
  localparam int PME_EN_BIT = 8;
  localparam int SEL_LSB = 9;
  localparam int SCALE_LSB = 13;
  localparam int PME_STAT_BIT = 15;
  localparam int PME_STATES_LSB = 24;

  // Table register layout: entry index and report value
  localparam int TBL_IDX_LSB = 16;
  localparam int TBL_VAL_W = 10;

  // Interrupt status bit positions
  localparam int IRQ_TURNOFF = 0;
  localparam int IRQ_ACK_SENT = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_STATE_CHG = 3;
  localparam int IRQ_W = 4;

  // Reset values
  localparam logic [1:0] STATE_RST = 2'h0;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [7:0] PME_STATES_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

  // Power states carried in the two-bit state field
  typedef enum logic [1:0] {
    PCPM_D0 = 2'h0,
    PCPM_D1 = 2'h1,
    PCPM_D2 = 2'h2,
    PCPM_D3 = 2'h3
  } pcpm_pstate_e;

  // Multiplier codes in the low bits of a report entry
  typedef enum logic [1:0] {
    PCPM_SCALE_UNKNOWN = 2'h0,
    PCPM_SCALE_TENTH = 2'h1,
    PCPM_SCALE_HUNDREDTH = 2'h2,
    PCPM_SCALE_THOUSANDTH = 2'h3
  } pcpm_scale_e;

  // Auxiliary power type reported by the board
  typedef enum logic [1:0] {
    PCPM_TYPE_NONE = 2'h0,
    PCPM_TYPE_AUX = 2'h1,
    PCPM_TYPE_PME_AUX = 2'h2,
    PCPM_TYPE_OTHER = 2'h3
  } pcpm_ptype_e;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pcpm_bus_s;

endpackage : pcpm_pkg

// ===== rtl/pcpm_rst_sync.sv
// Reset release synchroniser for the power management block
// Assumes rstn may drop at any time; release is aligned to mclk
`timescale 1ns/10ps
module pcpm_rst_sync (
  // Clock and raw reset
  input wire logic mclk,
  input wire logic rstn,
  // Synchronised reset
  output logic rst_sync_n
);

  logic meta_r;

  // Two stages so that release never lands near a clock edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      rst_sync_n <= meta_r;
    end
  end

endmodule : pcpm_rst_sync

// ===== rtl/pcpm_turnoff.sv
// Turn-off handshake: notice on a received turn-off message, then ack
// Assumes the link layer flags each received message with a one-cycle pulse
`timescale 1ns/10ps
module pcpm_turnoff (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link side
  input wire logic turnoff_msg_rx,
  output logic turnoff_ack_msg,
  // Application side
  output logic turnoff_notice_pulse,
  input wire logic turnoff_ack_request
);

  typedef enum logic [2:0] {
    TO_IDLE = 3'b001,
    TO_WAIT = 3'b010,
    TO_ACK = 3'b100
  } pcpm_to_e;

  pcpm_to_e state_r;

  // One notice per message, one cycle wide
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) turnoff_notice_pulse <= 1'b0;
    else turnoff_notice_pulse <= turnoff_msg_rx;
  end

  // An ack is sent only after a notice; stray requests are ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TO_IDLE;
      turnoff_ack_msg <= 1'b0;
    end else begin
      turnoff_ack_msg <= 1'b0;
      case (state_r)
        TO_IDLE: if (turnoff_msg_rx) state_r <= TO_WAIT;
        TO_WAIT: begin
          if (turnoff_ack_request) begin
            turnoff_ack_msg <= 1'b1;
            state_r <= TO_ACK;
          end
        end
        TO_ACK: state_r <= turnoff_msg_rx ? TO_WAIT : TO_IDLE;
        default: state_r <= TO_IDLE;
      endcase
    end
  end

  sequence notice_seen_s;
    turnoff_msg_rx ##1 turnoff_notice_pulse;
  endsequence

  sequence ack_sent_s;
    turnoff_ack_request ##1 turnoff_ack_msg;
  endsequence

  notice_follows_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    turnoff_msg_rx |-> notice_seen_s)
    else $error("turn-off notice missing after message");

  notice_pulse_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    turnoff_notice_pulse |-> $past(turnoff_msg_rx))
    else $error("turn-off notice without a message");

  ack_after_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state_r == TO_WAIT && turnoff_ack_request) |-> ack_sent_s)
    else $error("ack request not forwarded to the link");

endmodule : pcpm_turnoff

// ===== rtl/pcpm_top.sv
// Power management capability register bank of a PCIe endpoint
// Assumes a simple one-cycle register port and a link layer that
// flags turn-off messages and accepts wake and ack message strobes.
//
// Functional notes
// - State field bits 1:0 encode D0, D1, D2, D3.
// - State 3 means D3-Cold with aux power types, else D3-Hot.
// - Enable bit 8 allows or forbids the wake message.
// - Status bit 15 sets on every wake event, enable or not.
// - Scale bits 14:13 give the multiplier and ignore writes.
// - Selector bits 12:9 choose the reported power data entry.
// - Bits 31:24 report states able to send the wake message.
// - A received turn-off message raises the turn-off notice.
// - The notice is one cycle wide, once per message.
// - Report low bits code scale: unknown, 0.1, 0.01, 0.001.
// - Completer-only variant never initiates requests.
// - Only full variant reports the transmit width in the variant word.
// - Bus ports follow the published transfer handshake.
`timescale 1ns/10ps
module pcpm_top #(
  parameter bit FULL_FEATURED = 1'b1,
  parameter int TX_WIDTH = 64,
  parameter logic [7:0] PME_STATES = pcpm_pkg::PME_STATES_RST
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input pcpm_pkg::pcpm_bus_s bus,
  output logic [31:0] rdata_r,
  // Link layer
  input wire logic turnoff_msg_rx,
  output logic turnoff_ack_msg,
  output logic pme_msg_req,
  // Application side
  output logic turnoff_notice_pulse,
  input wire logic turnoff_ack_request,
  input wire logic wake_event,
  input wire pcpm_pkg::pcpm_ptype_e power_type,
  output logic [1:0] power_state_field,
  output logic d3_cold_r,
  output logic d3_hot_r,
  output logic [9:0] power_report_bus,
  // Interrupt
  output logic irq_r
);
  import pcpm_pkg::*;

  logic rst_n;
  logic [1:0] state_r;
  logic pme_en_r;
  logic pme_stat_r;
  logic [3:0] sel_r;
  logic [TBL_VAL_W-1:0] tbl_r [16];
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic wake_d_r;
  logic wake_rise;
  logic [15:0] tbl_seen_r;
  logic notice_int;
  logic ack_int;
  logic wr_cap;
  logic wr_stat;
  logic wr_mask;
  logic wr_tbl;
  logic [TBL_VAL_W-1:0] cur_entry;
  logic [1:0] scale_q;
  logic [31:0] cap_word;
  logic [31:0] rdata_nxt;
  logic [7:0] variant_word;

  // Reset release through two flops
  pcpm_rst_sync u_rst (
    .mclk(mclk),
    .rstn(rstn),
    .rst_sync_n(rst_n)
  );

  // Turn-off notice and ack handshake
  pcpm_turnoff u_turnoff (
    .mclk(mclk),
    .rst_n(rst_n),
    .turnoff_msg_rx(turnoff_msg_rx),
    .turnoff_ack_msg(ack_int),
    .turnoff_notice_pulse(notice_int),
    .turnoff_ack_request(turnoff_ack_request)
  );

  assign turnoff_notice_pulse = notice_int;
  assign turnoff_ack_msg = ack_int;

  // Write decode; the port never stalls, unmapped writes are dropped
  assign wr_cap = bus.wr && bus.addr == OFS_CAP;
  assign wr_stat = bus.wr && bus.addr == OFS_IRQ_STAT;
  assign wr_mask = bus.wr && bus.addr == OFS_IRQ_MASK;
  assign wr_tbl = bus.wr && bus.addr == OFS_TABLE;

  // Wake input is edge sensitive, so only the rising edge counts
  assign wake_rise = wake_event && !wake_d_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) wake_d_r <= 1'b0;
    else wake_d_r <= wake_event;
  end

  // Power state and enable; only writable fields take bus data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= STATE_RST;
      pme_en_r <= 1'b0;
      sel_r <= SEL_RST;
    end else if (wr_cap) begin
      state_r <= bus.wdata[STATE_LSB +: 2];
      pme_en_r <= bus.wdata[PME_EN_BIT];
      sel_r <= bus.wdata[SEL_LSB +: 4];
    end
  end

  // Wake status is sticky, write one clears, a new event wins the clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pme_stat_r <= 1'b0;
    else if (wake_rise) pme_stat_r <= 1'b1;
    else if (wr_cap && bus.wdata[PME_STAT_BIT]) pme_stat_r <= 1'b0;
  end

  // Wake message goes out only when enabled and allowed to initiate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pme_msg_req <= 1'b0;
    else pme_msg_req <= wake_rise && pme_en_r && FULL_FEATURED;
  end

  // Report table written by software; no reset needed for data storage
  always_ff @(posedge mclk) begin
    if (wr_tbl) tbl_r[bus.wdata[TBL_IDX_LSB +: 4]] <= bus.wdata[TBL_VAL_W-1:0];
  end

  // Entries that software has filled; the table itself has no reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tbl_seen_r <= '0;
    else if (wr_tbl) tbl_seen_r[bus.wdata[TBL_IDX_LSB +: 4]] <= 1'b1;
  end

  // Selected entry drives the report bus and the read-only scale field
  assign cur_entry = tbl_r[sel_r];
  assign scale_q = cur_entry[1:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) power_report_bus <= '0;
    else power_report_bus <= cur_entry;
  end

  // D3 flavour depends on the aux power type
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      d3_cold_r <= 1'b0;
      d3_hot_r <= 1'b0;
      power_state_field <= STATE_RST;
    end else begin
      power_state_field <= state_r;
      d3_cold_r <= state_r == PCPM_D3 && (power_type == PCPM_TYPE_AUX ||
                   power_type == PCPM_TYPE_PME_AUX);
      d3_hot_r <= state_r == PCPM_D3 && power_type != PCPM_TYPE_AUX &&
                  power_type != PCPM_TYPE_PME_AUX;
    end
  end

  // Capability word as software sees it; reserved bits stay zero
  always_comb begin
    cap_word = '0;
    cap_word[STATE_LSB +: 2] = state_r;
    cap_word[PME_EN_BIT] = pme_en_r;
    cap_word[SEL_LSB +: 4] = sel_r;
    cap_word[SCALE_LSB +: 2] = scale_q;
    cap_word[PME_STAT_BIT] = pme_stat_r;
    cap_word[PME_STATES_LSB +: 8] = PME_STATES;
  end

  // Variant word: bit 0 full featured, bits 7:1 transmit width / 8
  assign variant_word = FULL_FEATURED ?
    {7'(TX_WIDTH / 8), 1'b1} : 8'h00;

  // Interrupt events
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_TURNOFF] = notice_int;
    irq_set[IRQ_ACK_SENT] = ack_int;
    irq_set[IRQ_WAKE] = wake_rise;
    irq_set[IRQ_STATE_CHG] = wr_cap && bus.wdata[1:0] != state_r;
  end

  // Sticky status, write one to clear, new event beats the clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irq_stat_r <= '0;
    else if (wr_stat) irq_stat_r <= (irq_stat_r & ~bus.wdata[IRQ_W-1:0])
                                    | irq_set;
    else irq_stat_r <= irq_stat_r | irq_set;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irq_mask_r <= MASK_RST;
    else if (wr_mask) irq_mask_r <= bus.wdata[IRQ_W-1:0];
  end

  // Level interrupt, one flop behind the status for a clean output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irq_r <= 1'b0;
    else irq_r <= |(irq_stat_r & irq_mask_r);
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    case (bus.addr)
      OFS_CAP: rdata_nxt = cap_word;
      OFS_IRQ_STAT: rdata_nxt = 32'(irq_stat_r);
      OFS_IRQ_MASK: rdata_nxt = 32'(irq_mask_r);
      OFS_TABLE: rdata_nxt = {12'h000, sel_r, 6'h00, cur_entry};
      OFS_VARIANT: rdata_nxt = 32'(variant_word);
      default: rdata_nxt = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdata_r <= '0;
    else if (bus.rd) rdata_r <= rdata_nxt;
    else rdata_r <= '0;
  end

  // Register port steps that the read-back checks start from
  sequence cap_read_s;
    bus.rd && bus.addr == OFS_CAP;
  endsequence

  sequence cap_read_known_s;
    bus.rd && bus.addr == OFS_CAP && tbl_seen_r[sel_r];
  endsequence

  // Wake event steps, with and without the enable
  sequence wake_armed_s;
    wake_rise && pme_en_r;
  endsequence

  sequence wake_held_s;
    wake_rise && !pme_en_r;
  endsequence

  state_follow_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_cap |=> ##1 power_state_field == $past(bus.wdata[1:0], 2))
    else $error("state field does not follow the written value");

  state_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cap_read_s |=> rdata_r[STATE_LSB +: 2] == $past(state_r))
    else $error("state field reads back wrong");

  d3_cold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state_r == PCPM_D3 && power_type == PCPM_TYPE_PME_AUX)
    |=> d3_cold_r && !d3_hot_r)
    else $error("D3-Cold not flagged with aux power");

  d3_hot_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state_r == PCPM_D3 && power_type != PCPM_TYPE_AUX &&
     power_type != PCPM_TYPE_PME_AUX) |=> d3_hot_r && !d3_cold_r)
    else $error("D3-Hot not flagged without aux power");

  d3_clear_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_r != PCPM_D3 |=> !d3_cold_r && !d3_hot_r)
    else $error("D3 flag raised outside state 3");

  wake_gate_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pme_msg_req |-> $past(pme_en_r) && $past(wake_rise))
    else $error("wake message sent while disabled");

  wake_send_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wake_armed_s |=> pme_msg_req == FULL_FEATURED)
    else $error("enabled wake event did not send its message");

  wake_block_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wake_held_s |=> !pme_msg_req)
    else $error("disabled wake event sent a message");

  wake_status_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wake_rise |=> pme_stat_r)
    else $error("wake status not set by event");

  wake_sticky_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pme_stat_r && !(wr_cap && bus.wdata[PME_STAT_BIT])) |=> pme_stat_r)
    else $error("wake status dropped without a clear");

  wake_clear_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (wr_cap && bus.wdata[PME_STAT_BIT] && !wake_rise) |=> !pme_stat_r)
    else $error("wake status not cleared by writing one");

  scale_ro_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (wr_cap && !wr_tbl && tbl_seen_r[sel_r] &&
     bus.wdata[SEL_LSB +: 4] == sel_r) |=> $stable(scale_q))
    else $error("scale field moved on a register write");

  report_sel_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (tbl_seen_r[sel_r] && !wr_tbl) ##1 !wr_tbl
    |-> power_report_bus == $past(cur_entry))
    else $error("report bus does not show the selected entry");

  sel_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cap_read_s |=> rdata_r[SEL_LSB +: 4] == $past(sel_r))
    else $error("selector field reads back wrong");

  pme_states_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cap_read_s |=> rdata_r[31:24] == PME_STATES)
    else $error("capable states field wrong");

  scale_report_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cap_read_known_s |=> rdata_r[SCALE_LSB +: 2] == power_report_bus[1:0])
    else $error("scale field disagrees with the report bus");

  completer_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !FULL_FEATURED |-> !pme_msg_req)
    else $error("completer-only variant initiated a request");

  variant_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == OFS_VARIANT) |=> rdata_r[0] == FULL_FEATURED)
    else $error("variant bit reads back wrong");

  reserved_zero_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cap_read_s |=> rdata_r[22:16] == 7'h00 && rdata_r[7:2] == 6'h00)
    else $error("reserved capability bits not zero");

  read_window_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !bus.rd |=> rdata_r == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : pcpm_top

// ===== sim/pcpm_app_model.sv
// Application-side partner: acknowledges each turn-off notice
// Assumes the notice is a one-cycle pulse; the bench sets the ack delay
`timescale 1ns/10ps
module pcpm_app_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Handshake with the block
  input wire logic turnoff_notice_pulse,
  input wire logic [3:0] ack_delay,
  output logic turnoff_ack_request
);
  logic [4:0] wait_r;

  // Count down from each notice, then raise a one-cycle ack request;
  // a slow delay checks that the block keeps waiting for the ack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 5'h00;
      turnoff_ack_request <= 1'b0;
    end else begin
      turnoff_ack_request <= (wait_r == 5'h01);
      if (turnoff_notice_pulse) begin
        wait_r <= {1'b0, ack_delay} + 5'h01;
      end else if (wait_r != 5'h00) begin
        wait_r <= wait_r - 5'h01;
      end
    end
  end
endmodule : pcpm_app_model

// ===== sim/pcie_power_mgmt_capability_tb.sv
// Self-checking bench of the power management register bank
// Assumes the one-cycle register port and the app partner model
`timescale 1ns/10ps
module pcie_power_mgmt_capability_tb;
  import pcpm_pkg::*;
  localparam logic [7:0] PME_ST = 8'hA5;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  pcpm_bus_s bus = '0;
  logic turnoff_msg_rx = 1'b0;
  logic wake_event = 1'b0;
  pcpm_ptype_e power_type = PCPM_TYPE_NONE;
  logic [3:0] ack_delay = 4'h0;
  logic [31:0] rdata_r, co_rdata, got, got_co;
  logic turnoff_ack_msg, pme_msg_req, turnoff_notice_pulse, co_pme;
  logic turnoff_ack_request, d3_cold_r, d3_hot_r, irq_r, aux;
  logic [1:0] power_state_field;
  logic [9:0] power_report_bus, ent;
  int mismatches = 0;
  int n_compared = 0;
  int n_pme = 0, n_co_pme = 0, n_notice = 0, n_ack = 0, cycles = 0, pme0;

  pcpm_top #(.FULL_FEATURED(1'b1), .TX_WIDTH(64), .PME_STATES(PME_ST)) dut (
    .mclk, .rstn, .bus, .rdata_r, .turnoff_msg_rx, .turnoff_ack_msg,
    .pme_msg_req, .turnoff_notice_pulse, .turnoff_ack_request, .wake_event,
    .power_type, .power_state_field, .d3_cold_r, .d3_hot_r,
    .power_report_bus, .irq_r);
  // Completer-only twin shares all inputs so its requests can be watched
  pcpm_top #(.FULL_FEATURED(1'b0), .TX_WIDTH(64), .PME_STATES(PME_ST)) dut_co (
    .mclk, .rstn, .bus, .rdata_r(co_rdata), .turnoff_msg_rx,
    .turnoff_ack_msg(), .pme_msg_req(co_pme), .turnoff_notice_pulse(),
    .turnoff_ack_request, .wake_event, .power_type, .power_state_field(),
    .d3_cold_r(), .d3_hot_r(), .power_report_bus(), .irq_r());
  pcpm_app_model app (.mclk, .rst_n(rstn), .turnoff_notice_pulse,
    .ack_delay, .turnoff_ack_request);

  // Clock of 5 ns period
  always #2.5 mclk = ~mclk;

  // Pulse counters; counting high cycles also catches a widened pulse
  always @(posedge mclk) begin
    cycles++;
    if (pme_msg_req === 1'b1) n_pme++;
    if (co_pme === 1'b1) n_co_pme++;
    if (turnoff_notice_pulse === 1'b1) n_notice++;
    if (turnoff_ack_msg === 1'b1) n_ack++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    got = rdata_r;
    got_co = co_rdata;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic wake();
    @(posedge mclk);
    wake_event <= 1'b1;
    repeat (4) @(posedge mclk);
    wake_event <= 1'b0;
    idle(2);
  endtask : wake

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    idle(5);
    // Reset values, variant word and an unmapped address
    chk("irq_r", 32'h0, 32'(irq_r));
    rd(OFS_IRQ_STAT);
    chk("irq_stat", 32'h0, got);
    rd(OFS_IRQ_MASK);
    chk("irq_mask", 32'(MASK_RST), got);
    rd(OFS_VARIANT);
    chk("variant", 32'h11, got);
    chk("variant_co", 32'h0, got_co);
    idle(1);
    chk("rd_window", 32'h0, rdata_r);
    rd(8'h20);
    chk("unmapped", 32'h0, got);
    $display("test reset_map done");
    // Every scale code through the table; scale and reserved writes ignored
    for (int i = 0; i < 4; i++) begin
      ent = {8'h20 + 8'(i), 2'(i)};
      wr(OFS_TABLE, {12'h0, 4'(i), 6'h0, ent});
      wr(OFS_CAP, 32'hFF7F_60FC | (32'(i) << SEL_LSB));
      idle(2);
      rd(OFS_CAP);
      chk("cap", {PME_ST, 9'h0, 2'(i), 4'(i), 9'h0}, got);
      chk("report", 32'(ent), 32'(power_report_bus));
      rd(OFS_TABLE);
      chk("table", {12'h0, 4'(i), 6'h0, ent}, got);
    end
    $display("test scale_select done");
    // Each state against each power type
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 4; t++) begin
        @(posedge mclk);
        power_type <= pcpm_ptype_e'(t);
        wr(OFS_CAP, 32'(s));
        idle(3);
        aux = (t == 1) || (t == 2);
        chk("state", 32'(s), 32'(power_state_field));
        chk("d3_cold", 32'(s == 3 && aux), 32'(d3_cold_r));
        chk("d3_hot", 32'(s == 3 && !aux), 32'(d3_hot_r));
      end
      rd(OFS_CAP);
      chk("cap_state", {PME_ST, 22'h0, 2'(s)}, got);
    end
    rd(OFS_IRQ_STAT);
    chk("stat_chg", 32'h8, got);
    $display("test state_type done");
    // Wake event with enable off, then on, and its interrupt
    wr(OFS_CAP, 32'h0);
    wr(OFS_IRQ_STAT, 32'hF);
    pme0 = n_pme;
    wake();
    chk("pme_off", 32'(pme0), 32'(n_pme));
    rd(OFS_CAP);
    chk("cap_stat", {PME_ST, 24'h8000}, got);
    rd(OFS_IRQ_STAT);
    chk("irq_wake", 32'h4, got);
    wr(OFS_IRQ_MASK, 32'h4);
    idle(2);
    chk("irq_on", 32'h1, 32'(irq_r));
    wr(OFS_CAP, 32'h8100);
    wr(OFS_IRQ_STAT, 32'hF);
    idle(2);
    chk("irq_off", 32'h0, 32'(irq_r));
    rd(OFS_CAP);
    chk("cap_en", {PME_ST, 24'h0100}, got);
    wake();
    chk("pme_on", 32'(pme0 + 1), 32'(n_pme));
    chk("pme_co", 32'h0, 32'(n_co_pme));
    rd(OFS_CAP);
    chk("cap_stat2", {PME_ST, 24'h8100}, got);
    $display("test wake done");
    // Turn-off messages with a prompt and then a slow acknowledge
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STAT, 32'hF);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      ack_delay <= (k == 0) ? 4'h0 : 4'h6;
      turnoff_msg_rx <= 1'b1;
      @(posedge mclk);
      turnoff_msg_rx <= 1'b0;
      idle(14);
      chk("notices", 32'(k + 1), 32'(n_notice));
      chk("acks", 32'(k + 1), 32'(n_ack));
    end
    rd(OFS_IRQ_STAT);
    chk("irq_turnoff", 32'h3, got);
    $display("test turnoff done");
    wrap_up();
  end
endmodule : pcie_power_mgmt_capability_tb
